//--- rtl/tes_defines.svh
// Register offsets, field positions, reset values and timing constants of the exposure sequencer
`ifndef TES_DEFINES_SVH
`define TES_DEFINES_SVH

`define TES_CLK_HZ 25000000
`define TES_LINE_NS 31777
`define TES_LINE_CYC ((`TES_LINE_NS * (`TES_CLK_HZ / 1000000)) / 1000)
`define TES_RESET_DLY_NS 1500
`define TES_RESET_DLY_CYC ((`TES_RESET_DLY_NS * (`TES_CLK_HZ / 1000000) + 999) / 1000)
`define TES_FRAME_LINES 525
`define TES_PROG_MIN 2
`define TES_PROG_OFF 524
`define TES_PARTIAL_MARGIN 2
`define TES_READ_LINES 525

`define TES_ADDR_CTRL 12'h000
`define TES_ADDR_SHUT 12'h004
`define TES_ADDR_STAT 12'h008
`define TES_ADDR_FRAME 12'h00c

`define TES_CTRL_MODE_A 0
`define TES_CTRL_MODE_B 1
`define TES_CTRL_SER 2
`define TES_CTRL_SMODE_LO 3
`define TES_CTRL_SMODE_HI 4
`define TES_CTRL_BIN 5
`define TES_CTRL_PART 6
`define TES_CTRL_POL 7
`define TES_CTRL_RESET 8'h00

`define TES_SHUT_STEP_LO 0
`define TES_SHUT_STEP_HI 3
`define TES_SHUT_PROG_LO 4
`define TES_SHUT_PROG_HI 13
`define TES_SHUT_RESET 14'h0000
`define TES_FRAME_RESET 10'h20d

`endif

//--- rtl/tes_pkg.sv
// Types shared by the exposure sequencer files
package tes_pkg;
    typedef enum logic [1:0] {
        TES_MODE_CONT,
        TES_MODE_EDGE,
        TES_MODE_PULSE,
        TES_MODE_FDELAY
    } tes_mode_t;
    typedef enum logic [1:0] {
        TES_SHUT_LOCAL,
        TES_SHUT_STEP,
        TES_SHUT_PROG
    } tes_shut_src_t;
endpackage

//--- rtl/tes_line_timer.sv
// Line period timer: free-running crystal line, reset on demand, external sync override
`timescale 1ns/1ns
`include "tes_defines.svh"
module tes_line_timer #(
    parameter int LINE_CYC = `TES_LINE_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic phase_reset,
    input wire logic ext_sync_rise,
    input wire logic ext_sync_present,
    // Line tick
    output logic line_tick
);
    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic int_wrap;

    assign int_wrap = (cnt_q == 11'(LINE_CYC - 1));
    // External sync owns the line when present, otherwise the crystal count does
    assign line_tick = ext_sync_present ? ext_sync_rise : int_wrap;
    assign cnt_d = (phase_reset || int_wrap || (ext_sync_present && ext_sync_rise)) ? 11'h000 : cnt_q + 11'h001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 11'h000;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

//--- rtl/tes_sequencer.sv
// Trigger and exposure sequencer with APB registers, mode select and frame-valid output
// Function
// - Two selector bits choose continuous, edge preselect, pulse width or frame delay mode.
// - Line-reset: leading trigger edge resets line phase; exposure starts after the reset delay.
// - Line-reset exposure begins 1.5 us after the falling trigger edge.
// - Non-reset: exposure begins on first external line sync after the trigger.
// - Local three-bit selector gives eight fixed shutter steps.
// - Serial control gives nine steps or 2 to 524 lines, 524 meaning off.
// - Binning and partial scan never both active.
// - With binning or partial, exposure clamps to one frame time; pulse width mode is not clamped and ends on the first line after trigger rise.
// - Partial scan exposure never exceeds frame time minus two lines; pulse width mode ignores this limit.
// - One line period is 31.777 us.
// - Edge preselect reads out once the preset shutter time elapses.
// - Every triggered mode marks readout start on frame-valid.
// - Pulse width mode exposes from trigger fall to trigger rise.
// - Frame delay mode exposes preset time, readout waits for trigger rise.
// - Frame-valid polarity is selectable.
// - Default frame-valid is active high, one line long.
// - Without external line sync the internal crystal line timing is used.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "tes_defines.svh"
module tes_sequencer #(
    parameter int LINE_CYC = `TES_LINE_CYC,
    parameter int RESET_DLY_CYC = `TES_RESET_DLY_CYC,
    parameter int FRAME_LINES = `TES_FRAME_LINES,
    parameter int SYNC_LOSS_LINES = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Local selector pins
    input wire logic mode_select_bit_a,
    input wire logic mode_select_bit_b,
    input wire logic [2:0] shutter_select,
    input wire logic frame_valid_polarity_select,
    // Trigger and line sync inputs, active low trigger
    input wire logic trigger_n,
    input wire logic line_sync,
    input wire logic line_reset_sel,
    // Sensor control and frame grabber outputs
    output logic exposing,
    output logic readout_start,
    output logic frame_valid
);
    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers and edge detection
    logic [1:0] trig_s_q;
    logic [1:0] lsync_s_q;
    logic trig_q;
    logic lsync_q;
    logic [1:0] sw_s_q [5];
    logic [4:0] sw_raw;
    logic [4:0] sw_q;
    logic trig_fall;
    logic lsync_rise;

    assign sw_raw = {frame_valid_polarity_select, line_reset_sel, mode_select_bit_b, mode_select_bit_a,
                     shutter_select[2]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s_q <= 2'h3;
            lsync_s_q <= 2'h0;
            trig_q <= 1'b1;
            lsync_q <= 1'b0;
        end else begin
            trig_s_q <= {trig_s_q[0], trigger_n};
            lsync_s_q <= {lsync_s_q[0], line_sync};
            trig_q <= trig_s_q[1];
            lsync_q <= lsync_s_q[1];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sw_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sw_s_q[gi] <= 2'h0;
                end else begin
                    sw_s_q[gi] <= {sw_s_q[gi][0], sw_raw[gi]};
                end
            end
            assign sw_q[gi] = sw_s_q[gi][1];
        end
    endgenerate

    logic [1:0] shl_s_q [2];
    logic [1:0] shut_local;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_shut_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    shl_s_q[gi] <= 2'h0;
                end else begin
                    shl_s_q[gi] <= {shl_s_q[gi][0], shutter_select[gi]};
                end
            end
            assign shut_local[gi] = shl_s_q[gi][1];
        end
    endgenerate

    assign trig_fall = trig_q && !trig_s_q[1];
    assign lsync_rise = !lsync_q && lsync_s_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // APB registers
    logic [7:0] ctrl_q;
    logic [13:0] shut_q;
    logic [9:0] frame_q;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] status_word;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite; // Load in setup so read data stands through the access phase
    assign pready = 1'b1;
    assign addr_ok = (paddr == `TES_ADDR_CTRL) || (paddr == `TES_ADDR_SHUT) ||
                     (paddr == `TES_ADDR_STAT) || (paddr == `TES_ADDR_FRAME);
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `TES_CTRL_RESET;
            shut_q <= `TES_SHUT_RESET;
            frame_q <= `TES_FRAME_RESET;
        end else if (wr_en) begin
            if (paddr == `TES_ADDR_CTRL) begin
                ctrl_q <= pwdata[7:0];
            end
            if (paddr == `TES_ADDR_SHUT) begin
                shut_q <= pwdata[13:0];
            end
            if (paddr == `TES_ADDR_FRAME) begin
                frame_q <= pwdata[9:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                `TES_ADDR_CTRL: prdata <= {24'h000000, ctrl_q};
                `TES_ADDR_SHUT: prdata <= {18'h00000, shut_q};
                `TES_ADDR_STAT: prdata <= status_word;
                `TES_ADDR_FRAME: prdata <= {22'h000000, frame_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode and shutter selection
    tes_pkg::tes_mode_t mode;
    logic ser;
    logic bin_en;
    logic part_en;
    logic [9:0] exp_sel;
    logic [9:0] exp_lim;
    logic [9:0] exp_lines;
    logic [9:0] prog_lines;

    // Fixed step table in lines; step 0 is off (full frame)
    function automatic logic [9:0] step_lines(input logic [3:0] idx);
        case (idx)
            4'h0: step_lines = 10'(`TES_PROG_OFF);
            4'h1: step_lines = 10'h0fc;
            4'h2: step_lines = 10'h07e;
            4'h3: step_lines = 10'h03f;
            4'h4: step_lines = 10'h01f;
            4'h5: step_lines = 10'h010;
            4'h6: step_lines = 10'h008;
            4'h7: step_lines = 10'h004;
            4'h8: step_lines = 10'h002;
            default: step_lines = 10'(`TES_PROG_MIN);
        endcase
    endfunction

    assign ser = ctrl_q[`TES_CTRL_SER];
    // Local pins or serial control pick the mode
    assign mode = ser ? tes_pkg::tes_mode_t'(ctrl_q[`TES_CTRL_MODE_B:`TES_CTRL_MODE_A])
                      : tes_pkg::tes_mode_t'({sw_q[2], sw_q[1]});
    // Partial wins if software asks for both; the sensor cannot do both
    assign part_en = ctrl_q[`TES_CTRL_PART];
    assign bin_en = ctrl_q[`TES_CTRL_BIN] && !part_en;
    assign prog_lines = shut_q[`TES_SHUT_PROG_HI:`TES_SHUT_PROG_LO];
    // Local steps skip the off step, giving eight serial adds off and programmed lines
    assign exp_sel = !ser ? step_lines({1'b0, sw_q[0], shut_local} + 4'h1) :
                     (ctrl_q[`TES_CTRL_SMODE_HI:`TES_CTRL_SMODE_LO] == 2'(tes_pkg::TES_SHUT_PROG)) ?
                     ((prog_lines < 10'(`TES_PROG_MIN)) ? 10'(`TES_PROG_MIN) :
                      (prog_lines > 10'(`TES_PROG_OFF)) ? 10'(`TES_PROG_OFF) : prog_lines) :
                     step_lines(shut_q[`TES_SHUT_STEP_HI:`TES_SHUT_STEP_LO]);
    assign exp_lim = part_en ? frame_q - 10'(`TES_PARTIAL_MARGIN) :
                     bin_en ? frame_q : 10'(`TES_PROG_OFF);
    assign exp_lines = (exp_sel > exp_lim) ? exp_lim : exp_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // Line timing
    logic line_tick;
    logic phase_reset;
    logic [2:0] loss_q;
    logic ext_present;
    logic [10:0] gap_q;

    // External sync counts as present while edges keep coming
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 11'h000;
            loss_q <= 3'h0;
        end else if (lsync_rise) begin
            gap_q <= 11'h000;
            loss_q <= 3'(SYNC_LOSS_LINES);
        end else if (gap_q == 11'(LINE_CYC - 1)) begin
            gap_q <= 11'h000;
            loss_q <= (loss_q == 3'h0) ? 3'h0 : loss_q - 3'h1;
        end else begin
            gap_q <= gap_q + 11'h001;
        end
    end
    assign ext_present = (loss_q != 3'h0);
    tes_line_timer #(
        .LINE_CYC(LINE_CYC)
    ) u_line (
        .pclk(pclk),
        .presetn(presetn),
        .phase_reset(phase_reset),
        .ext_sync_rise(lsync_rise),
        .ext_sync_present(ext_present),
        .line_tick(line_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer
    typedef enum logic [2:0] {
        TES_ST_IDLE,
        TES_ST_DELAY,
        TES_ST_WAIT_LINE,
        TES_ST_EXPOSE,
        TES_ST_HOLD,
        TES_ST_READ
    } tes_state_t;
    tes_state_t st_q;
    tes_state_t st_d;
    logic [9:0] lcnt_q;
    logic [9:0] lcnt_d;
    logic [5:0] dcnt_q;
    logic hreset;
    logic triggered;
    logic exp_done;
    logic start_read;
    logic fv_q;

    // Line reset is chosen by pin routing; without external sync it is forced
    assign hreset = sw_q[3] || !ext_present;
    assign triggered = (mode != tes_pkg::TES_MODE_CONT);
    assign exp_done = line_tick && (lcnt_q + 10'h001 >= exp_lines);
    assign phase_reset = (st_q == TES_ST_IDLE) && triggered && trig_fall && hreset;
    assign start_read = (st_d == TES_ST_READ) && (st_q != TES_ST_READ);

    always_comb begin
        st_d = st_q;
        lcnt_d = lcnt_q;
        case (st_q)
            TES_ST_IDLE: begin
                lcnt_d = 10'h000;
                if (!triggered) begin
                    st_d = TES_ST_EXPOSE;
                end else if (trig_fall) begin
                    st_d = hreset ? TES_ST_DELAY : TES_ST_WAIT_LINE;
                end
            end
            TES_ST_DELAY: begin
                if (dcnt_q == 6'(RESET_DLY_CYC - 1)) begin
                    st_d = TES_ST_EXPOSE;
                end
            end
            TES_ST_WAIT_LINE: begin
                if (line_tick) begin
                    st_d = TES_ST_EXPOSE;
                end
            end
            TES_ST_EXPOSE: begin
                if (line_tick) begin
                    lcnt_d = lcnt_q + 10'h001;
                end
                if (mode == tes_pkg::TES_MODE_PULSE) begin
                    if (trig_s_q[1] && line_tick) begin // End on the first line after the rise
                        st_d = TES_ST_READ;
                    end
                end else if (exp_done) begin
                    st_d = (mode == tes_pkg::TES_MODE_FDELAY && !trig_s_q[1]) ? TES_ST_HOLD : TES_ST_READ;
                end
            end
            TES_ST_HOLD: begin
                if (trig_s_q[1] && line_tick) begin // Line aligned so frame-valid spans a full line
                    st_d = TES_ST_READ;
                end
            end
            TES_ST_READ: begin
                if (line_tick) begin
                    lcnt_d = lcnt_q + 10'h001;
                end
                if (line_tick && lcnt_q + 10'h001 >= 10'(FRAME_LINES)) begin
                    st_d = TES_ST_IDLE;
                end
            end
            default: st_d = TES_ST_IDLE;
        endcase
        if (st_d == TES_ST_READ && st_q != TES_ST_READ) begin
            lcnt_d = 10'h000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= TES_ST_IDLE;
            lcnt_q <= 10'h000;
            dcnt_q <= 6'h00;
        end else begin
            st_q <= st_d;
            lcnt_q <= lcnt_d;
            dcnt_q <= (st_q == TES_ST_DELAY) ? dcnt_q + 6'h01 : 6'h00;
        end
    end

    // Frame valid spans the first readout line; polarity by pin or register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fv_q <= 1'b0;
        end else if (start_read) begin
            fv_q <= 1'b1;
        end else if (line_tick) begin
            fv_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_valid <= 1'b0;
            exposing <= 1'b0;
            readout_start <= 1'b0;
        end else begin
            frame_valid <= fv_q ^ (sw_q[4] ^ ctrl_q[`TES_CTRL_POL]);
            exposing <= (st_d == TES_ST_EXPOSE);
            readout_start <= start_read;
        end
    end

    assign status_word = {16'h0000, lcnt_q, 1'b0, fv_q, ext_present, 3'(st_q)};
endmodule

//--- dv/tes_sequencer_properties.sv
// Port-level assertions for the exposure sequencer
`timescale 1ns/1ns
module tes_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sequencer outputs
    input wire logic exposing,
    input wire logic readout_start,
    input wire logic frame_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire bad = paddr > 12'h00c || paddr[1:0] != 2'h0;
    ////////////////////////////////////////////////////////////
    pready_high_a: assert property (pready) else $error("pready low");
    err_cause_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
    err_unmapped_a: assert property (acc && bad |-> pslverr) else $error("no error on unmapped");
    err_mapped_a: assert property (acc && !bad |-> !pslverr) else $error("error on mapped");
    rd_unmapped_a: assert property (acc && !pwrite && bad |-> prdata == 32'h0) else $error("unmapped data");
    start_pulse_a: assert property (readout_start |=> !readout_start [*8]) else $error("start repeats");
    fv_hold_a: assert property ($changed(frame_valid) |=> $stable(frame_valid) [*8]) else $error("fv short");
    expose_min_a: assert property ($rose(exposing) |=> exposing [*8]) else $error("exposure short");
    ////////////////////////////////////////////////////////////
    cover property ($rose(exposing));
    cover property (readout_start);
    cover property (acc && pslverr);
endmodule

bind tes_sequencer tes_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exposing(exposing), .readout_start(readout_start), .frame_valid(frame_valid));

//--- dv/tes_far_side.sv
// Far-side model: trigger source and line sync source
`timescale 1ns/1ns
module tes_far_side #(
    parameter int LINE_CYC = 20
) (
    // Clock
    input wire logic pclk,
    // Bench control
    input wire logic sync_on,
    // Driven pins
    output logic trigger_n,
    output logic line_sync
);
    int ph = 0;
    initial trigger_n = 1'b1;
    initial line_sync = 1'b0;
    // Sync keeps running every line while enabled, not only near a trigger
    always @(posedge pclk) begin
        ph <= (ph == LINE_CYC - 1) ? 0 : ph + 1;
        line_sync <= sync_on && ph < 2;
    end
    // With sync, fall just after the sync pulse to avoid one-line jitter
    task automatic pulse(input int low_cyc);
        int n;
        n = 0;
        while (sync_on && ph != 2 && n < LINE_CYC) begin
            @(posedge pclk);
            n++;
        end
        trigger_n <= 1'b0;
        repeat (low_cyc) @(posedge pclk);
        trigger_n <= 1'b1;
    endtask
endmodule

//--- dv/tes_sequencer_bench.sv
// Self-checking bench for the exposure sequencer
`timescale 1ns/1ns
`include "tes_defines.svh"
module tes_sequencer_bench;
    localparam int LC = 20;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, sync_on, trigger_n, line_sync, line_reset_sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, rerr, exposing, readout_start, frame_valid;
    logic mode_a, mode_b, pol;
    logic [2:0] shut_sel, idle;
    int miscompares = 0, checks_done = 0;
    int cyc = 0, t_fall = 0, t_up = 0, t_on = 0, t_off = 0, t_rd = 0, t_fv = 0, fv_len = 0;
    logic ex_q = 1'b0, tr_q = 1'b1, fv_q = 1'b0;
    always #20 pclk = ~pclk;
    tes_sequencer #(.LINE_CYC(LC), .FRAME_LINES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_select_bit_a(mode_a), .mode_select_bit_b(mode_b),
        .shutter_select(shut_sel), .frame_valid_polarity_select(pol), .trigger_n(trigger_n),
        .line_sync(line_sync), .line_reset_sel(line_reset_sel), .exposing(exposing),
        .readout_start(readout_start), .frame_valid(frame_valid));
    tes_far_side #(.LINE_CYC(LC)) far (.pclk(pclk), .sync_on(sync_on), .trigger_n(trigger_n),
        .line_sync(line_sync));
    ////////////////////////////////////////////////////////////
    // Edge timestamps in clock cycles
    always @(posedge pclk) begin
        cyc++;
        if (trigger_n === 1'b0 && tr_q === 1'b1) t_fall = cyc;
        if (trigger_n === 1'b1 && tr_q === 1'b0) t_up = cyc;
        if (exposing === 1'b1 && ex_q !== 1'b1) t_on = cyc;
        if (exposing !== 1'b1 && ex_q === 1'b1) t_off = cyc;
        if (readout_start === 1'b1) t_rd = cyc;
        if (frame_valid === 1'b1 && fv_q !== 1'b1) t_fv = cyc;
        if (frame_valid !== 1'b1 && fv_q === 1'b1) fv_len = cyc - t_fv;
        tr_q = trigger_n;
        ex_q = exposing;
        fv_q = frame_valid;
    end
    ////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic tmo(input string m);
        miscompares++;
        $display("unexpected at %0t: timeout %s", $time, m);
        complete_run();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi, input string m);
        checks_done++;
        if ($isunknown(got) || got < lo || got > hi) begin
            miscompares++;
            $display("unexpected at %0t: %s got %0h", $time, m, got);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rerr = pslverr;
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) tmo("apb");
    endtask
    // Poll status until the sequencer is back in idle
    task automatic wait_idle(input string m);
        int n;
        n = 0;
        do begin
            apb(`TES_ADDR_STAT, 1'b0, 32'h0);
            n++;
        end while (rdat[2:0] !== idle && n < 4000);
        if (n >= 4000) tmo(m);
    endtask
    // One trigger, only from idle, then wait for readout and for the return to idle
    task automatic shot(input int low);
        int n;
        wait_idle("idle before trigger");
        t_rd = 0;
        far.pulse(low);
        n = 0;
        while (t_rd <= t_fall && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 5000) tmo("readout");
        wait_idle("idle");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, sync_on, mode_a, mode_b, pol} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        shut_sel = 3'h0;
        line_reset_sel = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(`TES_ADDR_CTRL, 1'b0, 32'h0);
        chk(rdat, 32'h0, 32'h0, "ctrl reset");
        apb(`TES_ADDR_SHUT, 1'b0, 32'h0);
        chk(rdat, 32'h0, 32'h0, "shut reset");
        apb(`TES_ADDR_FRAME, 1'b0, 32'h0);
        chk(rdat, 32'h20d, 32'h20d, "frame reset");
        apb(12'h010, 1'b0, 32'h0);
        chk({rerr, rdat[30:0]}, 32'h80000000, 32'h80000000, "unmapped read");
        apb(12'h014, 1'b1, 32'hffffffff);
        chk(rerr, 1, 1, "unmapped write");
        idle = 3'h0; // Idle is the first sequencer state
        apb(`TES_ADDR_CTRL, 1'b1, 32'h15);
        apb(`TES_ADDR_SHUT, 1'b1, 32'h40);
        apb(`TES_ADDR_CTRL, 1'b0, 32'h0);
        chk(rdat, 32'h15, 32'h15, "ctrl readback");
        $display("register test done");
        shot(60);
        chk(t_on - t_fall, 38, 48, "reset delay");
        chk(t_off - t_on, 3 * LC, 5 * LC, "prog exposure");
        chk(t_rd - t_off, 0, 2, "edge readout");
        chk(fv_len, LC - 1, LC + 1, "fv length");
        $display("edge test done");
        apb(`TES_ADDR_CTRL, 1'b1, 32'h16);
        shot(150);
        chk(t_on - t_fall, 38, 48, "pulse start");
        chk(t_off - t_up, 0, LC + 6, "pulse end");
        $display("pulse test done");
        apb(`TES_ADDR_CTRL, 1'b1, 32'h17);
        apb(`TES_ADDR_SHUT, 1'b1, 32'h20);
        shot(5 * LC + 40);
        chk(t_off - t_on, LC, 3 * LC, "delay exposure");
        chk(t_rd - t_up, 0, LC + 6, "delay readout");
        $display("frame delay test done");
        apb(`TES_ADDR_CTRL, 1'b1, 32'h6d);
        apb(`TES_ADDR_SHUT, 1'b1, 32'h1);
        apb(`TES_ADDR_FRAME, 1'b1, 32'h4);
        shot(60);
        chk(t_off - t_on, LC, 3 * LC, "partial clamp");
        $display("partial scan test done");
        apb(`TES_ADDR_CTRL, 1'b1, 32'h15);
        sync_on <= 1'b1;
        line_reset_sel <= 1'b0;
        repeat (6 * LC) @(posedge pclk);
        shot(2 * LC + 10);
        chk(t_on - t_fall, 1, LC + 6, "sync start");
        $display("non-reset test done");
        sync_on <= 1'b0;
        line_reset_sel <= 1'b1;
        mode_a <= 1'b1;
        shut_sel <= 3'h7;
        pol <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(`TES_ADDR_CTRL, 1'b1, 32'h0);
        repeat (10) @(posedge pclk);
        chk(frame_valid, 1, 1, "fv inverted idle");
        shot(60);
        chk(t_off - t_on, LC, 3 * LC, "local shutter");
        pol <= 1'b0;
        mode_a <= 1'b0;
        $display("local pin test done");
        t_rd = 0;
        repeat (8000) @(posedge pclk);
        chk(t_rd, 1, 32'h7fffffff, "continuous readout");
        $display("continuous test done");
        complete_run();
    end
endmodule
